// [test/gs_host.sv]
// Grayscale source standing in for the host
`timescale 1ns/1ns
module gs_host (
  input wire clk_sys,
  input wire rst,
  input wire go,
  input wire [3:0] nz_mask,
  output reg gs_valid,
  output reg gs_nonzero,
  output reg gs_frame_end,
  output reg busy
);
  // ----------------------------------------
  // Frame sender
  // ----------------------------------------
  reg [1:0] k_r;
  // Four values a frame, the last marks the frame end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gs_valid <= 1'b0;
      gs_nonzero <= 1'b0;
      gs_frame_end <= 1'b0;
      busy <= 1'b0;
      k_r <= 2'h0;
    end else begin
      gs_valid <= busy;
      gs_frame_end <= busy && k_r == 2'h3;
      gs_nonzero <= busy ? nz_mask[k_r] : ~gs_nonzero; // Idle line toggles
      k_r <= busy ? k_r + 2'h1 : 2'h0;
      busy <= busy ? k_r != 2'h3 : go;
    end
  end
endmodule // gs_host

// [test/led_ctrl_chk.sv]
// Port checker for the LED control block
`timescale 1ns/1ns
module led_ctrl_chk #(
  parameter CH = 48
) (
  input wire clk_sys,
  input wire rst,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire gs_valid,
  input wire gs_nonzero,
  input wire gs_frame_end,
  input wire line_switch,
  input wire over_temp_in,
  input wire ref_short_in,
  input wire [CH-1:0] channel_output,
  input wire [7:0] bright_gain,
  input wire open_detect_run,
  input wire precharge_on,
  input wire power_save_state
);
  // ----------------------------------------
  // Helper state and properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg seen_nz_r;
  wire zero_end = gs_frame_end && !seen_nz_r && !(gs_valid && gs_nonzero);
  // Nonzero value seen since the last frame end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) seen_nz_r <= 1'b0;
    else if (gs_frame_end) seen_nz_r <= 1'b0;
    else if (gs_valid && gs_nonzero) seen_nz_r <= 1'b1;
  end
  property p_ps_in; $rose(power_save_state) |-> $past(zero_end); endproperty
  a_ps_in: assert property (p_ps_in) else $error("power save without zero frame");
  property p_ps_out; gs_valid && gs_nonzero |=> !power_save_state; endproperty
  a_ps_out: assert property (p_ps_out) else $error("power save kept on nonzero");
  property p_ps_off; power_save_state [*2] |-> channel_output == '0 && !open_detect_run; endproperty
  a_ps_off: assert property (p_ps_off) else $error("outputs alive in power save");
  property p_pre_on; line_switch [*2] |-> precharge_on; endproperty
  a_pre_on: assert property (p_pre_on) else $error("pull-up missing");
  property p_pre_off; !line_switch [*2] |-> !precharge_on; endproperty
  a_pre_off: assert property (p_pre_off) else $error("pull-up stuck on");
  property p_hot; over_temp_in [*4] |-> channel_output == '0; endproperty
  a_hot: assert property (p_hot) else $error("outputs on while hot");
  property p_short; ref_short_in [*4] |-> channel_output == '0; endproperty
  a_short: assert property (p_short) else $error("outputs on with short");
  property p_gain; !$past(rst) |-> bright_gain inside {8'h14, 8'h28, 8'h3c, 8'h52, 8'h66, 8'h73, 8'h90, 8'h9d}; endproperty
  a_gain: assert property (p_gain) else $error("illegal gain");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  c_ps: cover property (power_save_state [*2]);
  c_wake: cover property (power_save_state && gs_valid && gs_nonzero);
  c_pre: cover property (precharge_on);
endmodule // led_ctrl_chk

bind led_ctrl led_ctrl_chk #(.CH(CH)) u_chk (.*);

// [test/led_driver_fault_power_ctrl_bench.sv]
// Self-checking bench for the LED control block
`timescale 1ns/1ns
`include "led_ctrl_defs.vh"
module led_driver_fault_power_ctrl_bench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg go = 0, line_switch = 0, over_temp_in = 0, ref_short_in = 0;
  reg [3:0] nz_mask = 4'h0;
  reg [47:0] pwm_on = 48'h0, open_cmp = 48'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, gs_valid, gs_nonzero;
  wire gs_frame_end, busy, open_detect_run, precharge_on, power_save_state;
  wire [1:0] s_axi_bresp, s_axi_rresp, open_detect_threshold_sel;
  wire [31:0] s_axi_rdata;
  wire [47:0] channel_output;
  wire [7:0] bright_gain;
  wire [8:0] red_scale, green_scale, blue_scale;
  reg [63:0] gtab = 64'h9d90_7366_523c_2814;
  reg [31:0] rv;
  reg [1:0] rr;
  reg [8:0] code;
  integer n_mismatch = 0, check_count = 0, cyc = 0, i;
  led_ctrl #(.CH(48)) dut (.*);
  gs_host host (.*);
  always #50 clk_sys = ~clk_sys;
  // Compare and count
  task check(input [47:0] got, input [47:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Bus write, response left in rr
  task wr(input [7:0] a, input [31:0] d);
    reg ta, tw, tb;
    begin
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
        @(negedge clk_sys);
        ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        tb = s_axi_bvalid && s_axi_bready;
        rr = s_axi_bresp;
        @(posedge clk_sys);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
    end
  endtask
  // Bus read, data in rv and response in rr
  task rd(input [7:0] a);
    reg ta, tr;
    begin
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
        @(negedge clk_sys);
        ta = s_axi_arvalid && s_axi_arready;
        tr = s_axi_rvalid && s_axi_rready;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge clk_sys);
        if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
    end
  endtask
  // One grayscale frame from the host model
  task frame(input [3:0] m);
    begin
      @(posedge clk_sys);
      nz_mask <= m;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      @(negedge clk_sys);
      while (busy) @(negedge clk_sys);
      repeat (2) @(negedge clk_sys);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  // Watchdog
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check(bright_gain, gtab[`RST_BRIGHT*8 +: 8]);
    check({red_scale, green_scale, blue_scale}, {3{`RST_GROUP_CODE}});
    check(open_detect_threshold_sel, `RST_THR);
    rd(`OFS_WORD_A);
    check(rv[`WA_CATERPILLAR_BIT], 1'b0);
    rd(`OFS_WORD_B);
    check(rv[`WB_POWER_SAVE_BIT], 1'b0);
    // Every brightness code, colour code ends included
    for (i = 0; i < 8; i = i + 1) begin
      code = (i == 0) ? 9'h000 : {i[2:0], 6'h3f};
      wr(`OFS_WORD_A, {15'h0, code, 5'h00, i[2:0]});
      @(negedge clk_sys);
      check(bright_gain, gtab[i*8 +: 8]);
      check(red_scale, code);
    end
    wr(`OFS_STATUS, 32'h1);
    check(rr, `RESP_SLVERR);
    rd(8'h40);
    check({rr, rv}, {`RESP_SLVERR, 32'h0});
    // Open flag only while the channel is on
    pwm_on <= {48{1'b1}};
    open_cmp <= 48'h8;
    repeat (6) @(negedge clk_sys);
    rd(`OFS_OPEN_LO);
    check(rv[3:2], 2'b10);
    pwm_on <= ~48'h8;
    repeat (4) @(negedge clk_sys);
    rd(`OFS_OPEN_LO);
    open_cmp <= 48'h0;
    check(rv[3], 1'b0);
    check(channel_output, ~48'h8);
    // Caterpillar removal latches an open channel off
    wr(`OFS_WORD_A, 32'h0001_ff74);
    pwm_on <= {48{1'b1}};
    open_cmp <= 48'h20;
    repeat (6) @(negedge clk_sys);
    @(posedge clk_sys);
    open_cmp <= 48'h0;
    repeat (6) @(negedge clk_sys);
    check(channel_output, ~48'h20);
    rd(`OFS_LATCH_LO);
    check(rv[5], 1'b1);
    rd(`OFS_WORD_A);
    check(rv, 32'h0001_ff74);
    check(open_detect_threshold_sel, 2'h3);
    // Each fault forces all outputs off, then releases
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk_sys);
      {ref_short_in, over_temp_in} <= 2'b01 << i;
      repeat (5) @(negedge clk_sys);
      check(channel_output, 48'h0);
      @(posedge clk_sys);
      {ref_short_in, over_temp_in} <= 2'b00;
      repeat (5) @(negedge clk_sys);
      check(channel_output, ~48'h20);
    end
    // Pull-up follows the switching interval
    @(posedge clk_sys);
    line_switch <= 1'b1;
    repeat (3) @(negedge clk_sys);
    check(precharge_on, 1'b1);
    @(posedge clk_sys);
    line_switch <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check(precharge_on, 1'b0);
    // Zero frame enters power save, a nonzero value leaves it
    wr(`OFS_WORD_B, 32'h0203_0020);
    frame(4'h0);
    check(power_save_state, 1'b1);
    check(open_detect_run, 1'b0);
    check(channel_output, 48'h0);
    frame(4'h4);
    check(power_save_state, 1'b0);
    check(green_scale, `RST_GROUP_CODE);
    check(blue_scale, 9'h101);
    rd(`OFS_WORD_B);
    check(rv, 32'h0203_0020);
    conclude;
  end
endmodule // led_driver_fault_power_ctrl_bench

// [verilog/led_ctrl.v]
// Control, fault and power-save logic of a 48-channel LED sink driver
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "led_ctrl_defs.vh"

// Summary of operation
// [R01] Each colour group's output scale is its 9-bit code over 511, zero giving none and all-ones full.
// [R02] All three colour-group codes reset to 0x100.
// [R03] The 3-bit brightness code selects one of eight rising gain settings common to all channels.
// [R04] The brightness code resets to 4.
// [R05] The host should normally use brightness 4 and keep the extreme codes for range limits.
// [R06] A channel's open flag is 1 when its output is below the selected threshold, else 0.
// [R07] Open flags are valid only while the channel is on and read 0 when it is off.
// [R08] Caterpillar removal is enabled by bit 4 of word A, which resets to 0.
// [R09] With caterpillar removal on, a channel found open is latched off until reset.
// [R10] Power save is enabled by bit 5 of word B, which resets to 0.
// [R11] With power save on, an all-zero grayscale frame enters power-save state at once.
// [R12] In power-save state any non-zero grayscale value returns to normal at once.
// [R13] In power-save state the current outputs and open detection are disabled.
// [R14] The pre-charge pull-up is on during each common-line switching interval and off otherwise.
// [R15] Over-temperature forces all outputs off until the indication clears.
// [R16] Reference short forces all outputs off until the indication is released.
// [R17] Analog over-temperature, reference-short and open-compare levels are synchronised before use.
module led_ctrl #(
  parameter CH = 48
) (
  input wire clk_sys,
  input wire rst,
  // AXI4-Lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Grayscale stream and PWM state
  input wire gs_valid,
  input wire gs_nonzero,
  input wire gs_frame_end,
  input wire [CH-1:0] pwm_on,
  input wire line_switch,
  // Analog indications
  input wire [CH-1:0] open_cmp,
  input wire over_temp_in,
  input wire ref_short_in,
  // Analog controls
  output reg [CH-1:0] channel_output,
  output reg [7:0] bright_gain,
  output reg [`CODE_W-1:0] red_scale,
  output reg [`CODE_W-1:0] green_scale,
  output reg [`CODE_W-1:0] blue_scale,
  output reg [`THR_W-1:0] open_detect_threshold_sel,
  output reg open_detect_run,
  output reg precharge_on,
  output reg power_save_state
);
  // ----------------------------------------
  // Gain decode
  // ----------------------------------------
  // Eight rising gain steps, value is gain rounded
  function [7:0] gain_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: gain_of = 8'h14;
        3'h1: gain_of = 8'h28;
        3'h2: gain_of = 8'h3c;
        3'h3: gain_of = 8'h52;
        3'h4: gain_of = 8'h66;
        3'h5: gain_of = 8'h73;
        3'h6: gain_of = 8'h90;
        default: gain_of = 8'h9d;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [`BRIGHT_W-1:0] global_brightness_code_r;
  reg [`THR_W-1:0] thr_r;
  reg caterpillar_removal_enable_r;
  reg power_save_enable_r;
  reg [`CODE_W-1:0] red_group_code_r;
  reg [`CODE_W-1:0] green_group_code_r;
  reg [`CODE_W-1:0] blue_group_code_r;
  reg [CH-1:0] open_detect_flag_r;
  reg [CH-1:0] latched_off_r;
  reg frame_all_zero_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg aw_have_r;
  reg w_have_r;
  wire [CH-1:0] open_s;
  wire [1:0] flt_s;
  wire fault_off;
  wire outputs_en;
  wire do_write;

  // Analog levels cross into the clock domain
  sync2 #(.W(CH)) u_sync_open ( // [R17]
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(open_cmp),
    .sync_out(open_s)
  );
  sync2 #(.W(2)) u_sync_flt ( // [R17]
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({ref_short_in, over_temp_in}),
    .sync_out(flt_s)
  );

  assign fault_off = flt_s[0] | flt_s[1]; // [R15] [R16]
  assign outputs_en = ~fault_off & ~power_save_state; // [R13]
  assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;

  // ----------------------------------------
  // AXI write channel
  // ----------------------------------------
  // Address and data taken in either order, answer after both
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == `OFS_WORD_A || aw_addr_r == `OFS_WORD_B) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Control words
  // ----------------------------------------
  // Word A: brightness, threshold, caterpillar, red code; word B: green, blue, power save
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      global_brightness_code_r <= `RST_BRIGHT; // [R04]
      thr_r <= `RST_THR;
      caterpillar_removal_enable_r <= 1'b0; // [R08]
      power_save_enable_r <= 1'b0; // [R10]
      red_group_code_r <= `RST_GROUP_CODE; // [R02]
      green_group_code_r <= `RST_GROUP_CODE; // [R02]
      blue_group_code_r <= `RST_GROUP_CODE; // [R02]
    end else if (do_write) begin
      if (aw_addr_r == `OFS_WORD_A) begin
        if (w_strb_r[0]) begin
          global_brightness_code_r <= w_data_r[`WA_BRIGHT_LSB +: `BRIGHT_W];
          thr_r <= w_data_r[`WA_THR_LSB +: `THR_W];
          caterpillar_removal_enable_r <= w_data_r[`WA_CATERPILLAR_BIT];
        end
        if (w_strb_r[1])
          red_group_code_r[7:0] <= w_data_r[15:8];
        if (w_strb_r[2])
          red_group_code_r[8] <= w_data_r[16];
      end
      if (aw_addr_r == `OFS_WORD_B) begin
        if (w_strb_r[0])
          power_save_enable_r <= w_data_r[`WB_POWER_SAVE_BIT];
        if (w_strb_r[1])
          green_group_code_r[7:0] <= w_data_r[15:8];
        if (w_strb_r[2])
          green_group_code_r[8] <= w_data_r[16];
        if (w_strb_r[2])
          blue_group_code_r[6:0] <= w_data_r[23:17];
        if (w_strb_r[3])
          blue_group_code_r[8:7] <= w_data_r[25:24];
      end
    end
  end

  // ----------------------------------------
  // AXI read channel
  // ----------------------------------------
  // One read at a time, answer one cycle after address
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_WORD_A: s_axi_rdata <= {15'h0000, red_group_code_r, 1'b0, thr_r, caterpillar_removal_enable_r,
                                       1'b0, global_brightness_code_r};
          `OFS_WORD_B: s_axi_rdata <= {6'h00, blue_group_code_r, green_group_code_r, 2'h0,
                                       power_save_enable_r, 5'h00};
          `OFS_STATUS: s_axi_rdata <= {28'h0000000, frame_all_zero_r, flt_s[1], flt_s[0], power_save_state};
          `OFS_OPEN_LO: s_axi_rdata <= open_detect_flag_r[31:0];
          `OFS_OPEN_HI: s_axi_rdata <= {16'h0000, open_detect_flag_r[CH-1:32]};
          `OFS_LATCH_LO: s_axi_rdata <= latched_off_r[31:0];
          `OFS_LATCH_HI: s_axi_rdata <= {16'h0000, latched_off_r[CH-1:32]};
          `OFS_GAIN: s_axi_rdata <= {24'h000000, gain_of(global_brightness_code_r)};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Open detection and caterpillar latch
  // ----------------------------------------
  // Flag follows compare only while channel on and detector running
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      open_detect_flag_r <= {CH{1'b0}};
      latched_off_r <= {CH{1'b0}};
    end else begin
      open_detect_flag_r <= open_s & pwm_on & {CH{outputs_en}}; // [R06] [R07] [R13]
      if (caterpillar_removal_enable_r)
        latched_off_r <= latched_off_r | open_detect_flag_r; // [R09]
    end
  end

  // ----------------------------------------
  // Power save
  // ----------------------------------------
  // Track frame content; enter at an all-zero frame end, leave on any non-zero value
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frame_all_zero_r <= 1'b1;
      power_save_state <= 1'b0;
    end else begin
      if (gs_frame_end)
        frame_all_zero_r <= 1'b1; // Next frame starts clean even after a nonzero last value
      else if (gs_valid & gs_nonzero)
        frame_all_zero_r <= 1'b0;
      if (gs_valid & gs_nonzero)
        power_save_state <= 1'b0; // [R12]
      else if (gs_frame_end & power_save_enable_r & frame_all_zero_r)
        power_save_state <= 1'b1; // [R11] [R10]
      if (~power_save_enable_r)
        power_save_state <= 1'b0; // [R10]
    end
  end

  // ----------------------------------------
  // Analog control outputs
  // ----------------------------------------
  // Registered drive of current settings and output gates
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      channel_output <= {CH{1'b0}};
      bright_gain <= 8'h00;
      red_scale <= 9'h000;
      green_scale <= 9'h000;
      blue_scale <= 9'h000;
      open_detect_threshold_sel <= `RST_THR;
      open_detect_run <= 1'b0;
      precharge_on <= 1'b0;
    end else begin
      channel_output <= pwm_on & ~latched_off_r & {CH{outputs_en}}; // [R09] [R13] [R15] [R16]
      bright_gain <= gain_of(global_brightness_code_r); // [R03]
      red_scale <= red_group_code_r; // [R01]
      green_scale <= green_group_code_r; // [R01]
      blue_scale <= blue_group_code_r; // [R01]
      open_detect_threshold_sel <= thr_r; // [R06]
      open_detect_run <= ~power_save_state; // [R13]
      precharge_on <= line_switch; // [R14]
    end
  end
endmodule // led_ctrl

// [verilog/led_ctrl_defs.vh]
// Constants for the LED driver control and protection block
`ifndef LED_CTRL_DEFS_VH
`define LED_CTRL_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_WORD_A 8'h00
`define OFS_WORD_B 8'h04
`define OFS_STATUS 8'h08
`define OFS_OPEN_LO 8'h0c
`define OFS_OPEN_HI 8'h10
`define OFS_LATCH_LO 8'h14
`define OFS_LATCH_HI 8'h18
`define OFS_GAIN 8'h1c
// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define WA_BRIGHT_LSB 0
`define WA_THR_LSB 5
`define WA_CATERPILLAR_BIT 4
`define WB_POWER_SAVE_BIT 5
`define CODE_W 9
`define BRIGHT_W 3
`define THR_W 2
// ----------------------------------------
// Reset values and the full-scale colour code
// ----------------------------------------
`define RST_BRIGHT 3'h4
`define RST_GROUP_CODE 9'h100
`define RST_THR 2'h0
`define FULL_CODE 9'h1ff
// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [verilog/sync2.v]
// Two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
module sync2 #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire rst,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_r;

  // First stage feeds only the second
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // sync2
